// ---- verilog/otp_region_pkg.sv ----
package otp_region_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENTER_OTP  = 8'hb1;
  localparam logic [7:0] OP_EXIT_OTP   = 8'hc1;
  localparam logic [7:0] OP_RD_LOCK    = 8'h2b;
  localparam logic [7:0] OP_WR_LOCK    = 8'h2f;
  localparam logic [7:0] OP_WR_STAT1   = 8'h01;
  localparam logic [7:0] OP_WR_STAT2   = 8'h31;
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_ERASE_4K   = 8'h20;

  // ----------------------------------------------------------------
  // Region layout and lock state fields
  // ----------------------------------------------------------------
  localparam int          OTP_BYTES     = 512;
  localparam logic [23:0] SERIAL_FIRST  = 24'h000000;
  localparam logic [23:0] SERIAL_LAST   = 24'h00000f;
  localparam logic [23:0] USER_FIRST    = 24'h000010;
  localparam logic [23:0] USER_LAST     = 24'h0001ff;
  localparam int          LOCK_FACTORY  = 0;
  localparam int          LOCK_CUSTOMER = 1;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  // ----------------------------------------------------------------
  // Frame byte counts
  // ----------------------------------------------------------------
  localparam logic [2:0] BYTES_OPCODE   = 3'd1;
  localparam logic [2:0] BYTES_LOCK_WR  = 3'd2;
  localparam logic [2:0] BYTES_ADDR_END = 3'd4;
  localparam logic [2:0] BYTES_STAT_WR  = 3'd2;
  localparam logic [2:0] BYTE_SAT       = 3'd7;
  localparam logic [2:0] BIT_LAST       = 3'd7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int PUW_MIN_US   = 1000;
  localparam int PUW_CYCLES   = PUW_MIN_US * CLK_MHZ;
  localparam int PUW_W        = 18;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_ADDR,
    PH_RDATA,
    PH_WDATA,
    PH_LOCK,
    PH_STAT,
    PH_IGNORE
  } phase_t;

endpackage : otp_region_pkg

// ---- verilog/secured_otp_region_control.sv ----
// Contract
// - Opcode B1h enters OTP region mode.
// - OTP mode never aliases main array.
// - Normal read/program serve OTP region.
// - Status and lock writes rejected in OTP.
// - Locked region accepts reads only.
// - OTP mode refuses all main writes.
// - Opcode C1h leaves OTP mode.
// - 2Bh returns lock byte repeatedly, anytime.
// - Bit 0 shows factory lock, read-only.
// - Bit 1 customer lock is permanent.
// - Bits 7 to 2 reserved.
// - 2Fh sets bit 1 without enable.
// - 2Fh needs byte-exact chip select release.
// - Bytes 00h-0Fh hold serial number.
// - Bytes 10h-1FFh hold user data.
// - Writes ignored during power-up delay.
module secured_otp_region_control
#(
  parameter int unsigned PUW_COUNT = otp_region_pkg::PUW_CYCLES
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Serial link pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  // Non-volatile lock state as stored
  input  wire logic        factory_lock_nv,
  input  wire logic        customer_lockdown_nv,
  output logic             customer_lockdown_flag,
  // Main array side
  output logic [23:0]      main_addr,
  input  wire logic [7:0]  main_rd_data,
  output logic             main_prog_pulse,
  output logic [7:0]       main_prog_data,
  output logic             main_erase_pulse,
  output logic             status_wr_pulse,
  output logic             status_wr_sel2,
  output logic [7:0]       status_wr_data,
  // Mode state
  output logic             otp_mode
);
  import otp_region_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic cs_m_q, cs_s_q, cs_d_q, sck_m_q, sck_s_q, sck_d_q, mo_m_q, mo_s_q;
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cs_m_q  <= 1'b1;
      cs_s_q  <= 1'b1;
      cs_d_q  <= 1'b1;
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_d_q <= 1'b0;
      mo_m_q  <= 1'b0;
      mo_s_q  <= 1'b0;
    end
    else
    begin
      cs_m_q  <= cs_n;
      cs_s_q  <= cs_m_q;
      cs_d_q  <= cs_s_q;
      sck_m_q <= sclk;
      sck_s_q <= sck_m_q;
      sck_d_q <= sck_s_q;
      mo_m_q  <= mosi;
      mo_s_q  <= mo_m_q;
    end
  end

  logic sel, rise, fall, frame_end;
  assign sel       = !cs_s_q;
  assign rise      = sel && sck_s_q && !sck_d_q;
  assign fall      = sel && !sck_s_q && sck_d_q;
  assign frame_end = cs_s_q && !cs_d_q;

  // ----------------------------------------------------------------
  // Power-up write inhibit
  // ----------------------------------------------------------------
  logic [PUW_W-1:0] puw_q;
  logic             wr_ok;
  assign wr_ok = (puw_q == PUW_W'(PUW_COUNT));
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      puw_q <= '0;
    else if (!wr_ok)
      puw_q <= puw_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // Bit and byte framing
  // ----------------------------------------------------------------
  logic [2:0] bit_q, byte_q;
  logic [7:0] sh_q, rx_byte;
  logic       byte_done;
  assign rx_byte   = {sh_q[6:0], mo_s_q};
  assign byte_done = rise && (bit_q == BIT_LAST);
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !sel)
    begin
      bit_q  <= '0;
      byte_q <= '0;
      sh_q   <= '0;
    end
    else if (rise)
    begin
      sh_q  <= rx_byte;
      bit_q <= bit_q + 1'b1;
      if (bit_q == BIT_LAST && byte_q != BYTE_SAT)
        byte_q <= byte_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Lock state and mode
  // ----------------------------------------------------------------
  logic       init_q, fac_q, cust_q, otp_q, wel_q;
  logic [7:0] opc_q, lock_byte, lock_dat_q;
  logic       region_locked;
  assign lock_byte = {6'b000000, cust_q, fac_q};
  assign region_locked = fac_q || cust_q;
  assign customer_lockdown_flag = cust_q;
  assign otp_mode = otp_q;
  logic lock_wr_go;
  assign lock_wr_go = frame_end && opc_q == OP_WR_LOCK && byte_q == BYTES_LOCK_WR
                      && bit_q == '0 && !otp_q && wr_ok;
  // Stored levels are caught after release, never under reset.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      init_q <= 1'b0;
      fac_q  <= 1'b0;
      cust_q <= 1'b0;
    end
    else if (!init_q)
    begin
      init_q <= 1'b1;
      fac_q  <= factory_lock_nv;
      cust_q <= customer_lockdown_nv;
    end
    else if (lock_wr_go && lock_dat_q[LOCK_CUSTOMER])
      cust_q <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      otp_q <= 1'b0;
    else if (byte_done && byte_q == '0 && rx_byte == OP_ENTER_OTP)
      otp_q <= 1'b1;
    else if (byte_done && byte_q == '0 && rx_byte == OP_EXIT_OTP)
      otp_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Command decode and phase
  // ----------------------------------------------------------------
  phase_t     ph_q;
  logic [23:0] addr_q;
  logic [7:0]  otp_mem [OTP_BYTES];
  logic        in_region, prog_hit, main_wr_ok;
  assign in_region  = (addr_q >= SERIAL_FIRST) && (addr_q <= USER_LAST);
  assign main_wr_ok = wel_q && wr_ok && !otp_q;
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !sel)
      ph_q <= PH_OPCODE;
    else if (byte_done)
    begin
      unique case (ph_q)
        PH_OPCODE:
          unique case (rx_byte)
            OP_READ, OP_PROGRAM, OP_ERASE_4K: ph_q <= PH_ADDR;
            OP_RD_LOCK:                       ph_q <= PH_RDATA;
            OP_WR_LOCK:                       ph_q <= PH_LOCK;
            OP_WR_STAT1, OP_WR_STAT2:         ph_q <= PH_STAT;
            default:                          ph_q <= PH_IGNORE;
          endcase
        PH_ADDR:
          if (byte_q == BYTES_ADDR_END - 1'b1)
            ph_q <= (opc_q == OP_READ)    ? PH_RDATA :
                    (opc_q == OP_PROGRAM) ? PH_WDATA : PH_IGNORE;
        PH_LOCK, PH_STAT: ph_q <= PH_IGNORE;
        PH_IDLE, PH_RDATA, PH_WDATA, PH_IGNORE: ph_q <= ph_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      opc_q      <= '0;
      addr_q     <= '0;
      lock_dat_q <= '0;
    end
    else if (byte_done)
    begin
      if (ph_q == PH_OPCODE)
        opc_q <= rx_byte;
      if (ph_q == PH_ADDR)
        addr_q <= {addr_q[15:0], rx_byte};
      else if (ph_q == PH_RDATA || ph_q == PH_WDATA)
        addr_q <= addr_q + 1'b1;
      if (ph_q == PH_LOCK)
        lock_dat_q <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Write enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      wel_q <= 1'b0;
    else if (byte_done && ph_q == PH_OPCODE && rx_byte == OP_WR_ENABLE && wr_ok)
      wel_q <= 1'b1;
    else if (frame_end && (opc_q == OP_PROGRAM || opc_q == OP_ERASE_4K
             || opc_q == OP_WR_STAT1 || opc_q == OP_WR_STAT2))
      wel_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Region programming and main array writes
  // ----------------------------------------------------------------
  assign prog_hit = byte_done && ph_q == PH_WDATA && otp_q && wel_q && wr_ok
                    && !region_locked && in_region;

  // Region content is non-volatile in silicon; here it starts erased.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < OTP_BYTES; i++)
        otp_mem[i] <= ERASED_BYTE;
    end
    else if (prog_hit)
      otp_mem[addr_q[8:0]] <= otp_mem[addr_q[8:0]] & rx_byte;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      main_prog_pulse  <= 1'b0;
      main_prog_data   <= '0;
      main_erase_pulse <= 1'b0;
      status_wr_pulse  <= 1'b0;
      status_wr_sel2   <= 1'b0;
      status_wr_data   <= '0;
      main_addr        <= '0;
    end
    else
    begin
      main_prog_pulse  <= byte_done && ph_q == PH_WDATA && main_wr_ok;
      main_erase_pulse <= frame_end && opc_q == OP_ERASE_4K && byte_q == BYTES_ADDR_END
                          && bit_q == '0 && main_wr_ok;
      status_wr_pulse  <= byte_done && ph_q == PH_STAT && main_wr_ok;
      if (byte_done)
      begin
        main_prog_data <= rx_byte;
        status_wr_data <= rx_byte;
        status_wr_sel2 <= (opc_q == OP_WR_STAT2);
      end
      main_addr        <= addr_q;
    end
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  logic [7:0]  tx_q, next_tx;
  logic [23:0] rd_addr;
  logic        rd_in_region;
  assign rd_addr      = (ph_q == PH_ADDR) ? {addr_q[15:0], rx_byte} : addr_q + 1'b1;
  assign rd_in_region = (rd_addr <= USER_LAST);
  always_comb
  begin
    if (ph_q == PH_OPCODE || opc_q == OP_RD_LOCK)
      next_tx = lock_byte;
    else if (otp_q)
      next_tx = rd_in_region ? otp_mem[rd_addr[8:0]] : ERASED_BYTE;
    else
      next_tx = main_rd_data;
  end
  logic load_tx;
  assign load_tx = byte_done && (ph_q == PH_RDATA ||
                   (ph_q == PH_OPCODE && rx_byte == OP_RD_LOCK) ||
                   (ph_q == PH_ADDR && byte_q == BYTES_ADDR_END - 1'b1 && opc_q == OP_READ));
  // The next byte must be ready before the falling edge that shows its first bit.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      tx_q    <= '0;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end
    else if (!sel)
    begin
      miso_oe <= 1'b0;
    end
    else if (load_tx)
      tx_q <= next_tx;
    else if (fall && ph_q == PH_RDATA)
    begin
      miso    <= tx_q[7];
      miso_oe <= 1'b1;
      tx_q    <= {tx_q[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_enter_byte;
    byte_done && ph_q == PH_OPCODE && rx_byte == OP_ENTER_OTP;
  endsequence
  sequence s_exit_byte;
    byte_done && ph_q == PH_OPCODE && rx_byte == OP_EXIT_OTP;
  endsequence

  a_enter_otp_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_enter_byte |=> otp_mode)
    else $error("OTP mode not entered");
  a_exit_otp_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_exit_byte |=> !otp_mode)
    else $error("OTP mode not left");
  a_no_main_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    otp_mode && $past(otp_mode) |-> !main_prog_pulse && !main_erase_pulse)
    else $error("Main array written in OTP mode");
  a_no_stat_otp: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(otp_mode) && otp_mode |-> !status_wr_pulse)
    else $error("Status write accepted in OTP mode");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    init_q && $past(init_q) && $past(cust_q) |-> cust_q)
    else $error("Customer lock cleared");
  a_lock_needs_frame: assert property (@(posedge ref_clk) disable iff (!reset_n)
    init_q && $past(init_q) && $rose(cust_q) |-> $past(frame_end)
      && $past(opc_q) == OP_WR_LOCK && $past(byte_q) == BYTES_LOCK_WR)
    else $error("Lock set without exact frame");
  a_locked_region_ro: assert property (@(posedge ref_clk) disable iff (!reset_n)
    region_locked |-> !prog_hit)
    else $error("Locked region programmed");
  a_puw_inhibit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !wr_ok |=> !main_prog_pulse && !status_wr_pulse && !wel_q)
    else $error("Write accepted during power-up delay");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    load_tx && opc_q == OP_RD_LOCK && ph_q == PH_RDATA |=> tx_q[7:2] == 6'b000000)
    else $error("Reserved lock bits not zero");
  a_region_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
    prog_hit |-> addr_q <= USER_LAST && otp_mode)
    else $error("Program outside region");

endmodule : secured_otp_region_control

// ---- verif/host_spi_model.sv ----
module host_spi_model (
  // Clock
  input  wire logic ref_clk,
  // Link pins
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----
  // Mode 0 frames, 125 ns bit time
  // ----
  localparam int LOW  = 13;
  localparam int HIGH = 12;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // The clock stands still between frames, and a released data line flips so that
  // nothing can lean on a stale value.
  task automatic frame(input int n, input logic [63:0] d, output logic [63:0] q);
    q = '0;
    cs_n <= 1'b0;
    repeat (LOW) @(posedge ref_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi <= d[i];
      repeat (LOW) @(posedge ref_clk);
      sclk <= 1'b1;
      @(posedge ref_clk);
      q[i] = miso_oe ? miso : 1'bx;
      repeat (HIGH - 1) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (LOW) @(posedge ref_clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge ref_clk);
  endtask : frame
endmodule : host_spi_model

// ---- verif/tb_secured_otp_region_control.sv ----
module tb_secured_otp_region_control
  import otp_region_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----
  // Signals
  // ----
  localparam int PUW = 2000;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cs_n, sclk, mosi, miso, miso_oe, cust_flag, otp_mode;
  logic        fac_nv = 1'b0;
  logic        cust_nv = 1'b0;
  logic [23:0] main_addr, prog_addr;
  logic [7:0]  main_rd = 8'h3c;
  logic        prog_p, erase_p, stat_p, stat_sel2, sel_last;
  logic [7:0]  prog_data, stat_data, prog_last, stat_last;
  logic [7:0]  prog_cnt = 8'h00;
  logic [7:0]  erase_cnt = 8'h00;
  logic [7:0]  stat_cnt = 8'h00;
  logic [63:0] q;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #2.5 ref_clk = ~ref_clk;

  secured_otp_region_control #(
    .PUW_COUNT(PUW)
  ) u_dut (
    .ref_clk               (ref_clk),
    .reset_n               (reset_n),
    .cs_n                  (cs_n),
    .sclk                  (sclk),
    .mosi                  (mosi),
    .miso                  (miso),
    .miso_oe               (miso_oe),
    .factory_lock_nv       (fac_nv),
    .customer_lockdown_nv  (cust_nv),
    .customer_lockdown_flag(cust_flag),
    .main_addr             (main_addr),
    .main_rd_data          (main_rd),
    .main_prog_pulse       (prog_p),
    .main_prog_data        (prog_data),
    .main_erase_pulse      (erase_p),
    .status_wr_pulse       (stat_p),
    .status_wr_sel2        (stat_sel2),
    .status_wr_data        (stat_data),
    .otp_mode              (otp_mode)
  );

  host_spi_model u_host (
    .ref_clk(ref_clk),
    .cs_n   (cs_n),
    .sclk   (sclk),
    .mosi   (mosi),
    .miso   (miso),
    .miso_oe(miso_oe)
  );

  // Pulses are counted here, so a scenario sees both extra and missing ones.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (prog_p === 1'b1)
    begin
      prog_cnt  <= prog_cnt + 8'h01;
      prog_last <= prog_data;
      prog_addr <= main_addr;
    end
    if (erase_p === 1'b1)
      erase_cnt <= erase_cnt + 8'h01;
    if (stat_p === 1'b1)
    begin
      stat_cnt  <= stat_cnt + 8'h01;
      stat_last <= stat_data;
      sel_last  <= stat_sel2;
    end
    if (cyc == 60000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // ----
  // Helpers
  // ----
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic fr(input int n, input logic [63:0] d);
    u_host.frame(n, d, q);
  endtask : fr

  task automatic prog(input logic [23:0] a, input logic [7:0] v);
    fr(8, 64'(OP_WR_ENABLE));
    fr(40, {24'h0, OP_PROGRAM, a, v});
  endtask : prog

  task automatic rd(input logic [23:0] a, input logic [15:0] exp, input string what);
    fr(48, {16'h0, OP_READ, a, 16'h0});
    chk(what, {8'h0, exp}, {8'h0, q[15:0]});
  endtask : rd

  task automatic rdlock(input logic [15:0] exp);
    fr(24, {40'h0, OP_RD_LOCK, 16'h0});
    chk("lock byte", {8'h0, exp}, {8'h0, q[15:0]});
  endtask : rdlock

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
  endtask : do_reset

  // ----
  // Scenarios
  // ----
  task automatic t_power_up();
    rdlock(16'h0000);
    fr(16, {48'h0, OP_WR_LOCK, 8'h02});
    chk_bit("early lock write", 1'b0, cust_flag);
    repeat (PUW) @(posedge ref_clk);
    $display("power up test done");
  endtask : t_power_up

  task automatic t_main();
    logic [7:0] p0;
    logic [7:0] s0;
    logic [7:0] e0;
    p0 = prog_cnt;
    s0 = stat_cnt;
    e0 = erase_cnt;
    prog(24'h000123, 8'ha5);
    chk("main program", {8'h0, p0 + 8'h01, 8'ha5}, {8'h0, prog_cnt, prog_last});
    chk("main address", 24'h000123, prog_addr);
    fr(8, 64'(OP_WR_ENABLE));
    fr(16, {48'h0, OP_WR_STAT1, 8'h55});
    chk("status one", {8'h0, s0 + 8'h01, 8'h55}, {8'h0, stat_cnt, stat_last});
    chk_bit("status select", 1'b0, sel_last);
    fr(8, 64'(OP_WR_ENABLE));
    fr(16, {48'h0, OP_WR_STAT2, 8'h66});
    chk("status two", {8'h0, s0 + 8'h02, 8'h66}, {8'h0, stat_cnt, stat_last});
    chk_bit("status select", 1'b1, sel_last);
    fr(8, 64'(OP_WR_ENABLE));
    fr(32, {32'h0, OP_ERASE_4K, 24'h001000});
    chk("main erase", {16'h0, e0 + 8'h01}, {16'h0, erase_cnt});
    $display("main array test done");
  endtask : t_main

  task automatic t_otp();
    logic [23:0] c0;
    c0 = {prog_cnt, erase_cnt, stat_cnt};
    fr(8, 64'(OP_ENTER_OTP));
    chk_bit("otp mode", 1'b1, otp_mode);
    rd(24'h000000, 16'hffff, "serial field");
    prog(24'h000010, 8'ha5);
    rd(24'h000010, 16'ha5ff, "user area");
    prog(24'h00000f, 8'h12);
    rd(24'h00000f, 16'h12a5, "serial edge");
    prog(24'h0001ff, 8'h5a);
    prog(24'h000200, 8'h00);
    rd(24'h0001ff, 16'h5aff, "region end");
    fr(8, 64'(OP_WR_ENABLE));
    fr(16, {48'h0, OP_WR_STAT1, 8'h55});
    fr(8, 64'(OP_WR_ENABLE));
    fr(16, {48'h0, OP_WR_STAT2, 8'h66});
    fr(16, {48'h0, OP_WR_LOCK, 8'h02});
    fr(8, 64'(OP_WR_ENABLE));
    fr(32, {32'h0, OP_ERASE_4K, 24'h000000});
    chk("write pulses", c0, {prog_cnt, erase_cnt, stat_cnt});
    chk_bit("lock in otp", 1'b0, cust_flag);
    fr(8, 64'(OP_EXIT_OTP));
    chk_bit("otp mode", 1'b0, otp_mode);
    rd(24'h000010, 16'h3c3c, "main after exit");
    $display("otp access test done");
  endtask : t_otp

  task automatic t_lock();
    fr(15, {49'h0, OP_WR_LOCK, 7'h01});
    chk_bit("short lock frame", 1'b0, cust_flag);
    fr(17, {47'h0, OP_WR_LOCK, 8'h02, 1'b0});
    chk_bit("long lock frame", 1'b0, cust_flag);
    fr(16, {48'h0, OP_WR_LOCK, 8'h02});
    chk_bit("lock flag", 1'b1, cust_flag);
    rdlock(16'h0202);
    fr(16, {48'h0, OP_WR_LOCK, 8'h00});
    fr(8, 64'(OP_ENTER_OTP));
    prog(24'h000011, 8'h00);
    rd(24'h000010, 16'ha5ff, "locked region");
    fr(8, 64'(OP_EXIT_OTP));
    rdlock(16'h0202);
    $display("lock write test done");
  endtask : t_lock

  task automatic t_factory();
    fac_nv  <= 1'b1;
    cust_nv <= 1'b1;
    do_reset();
    rdlock(16'h0303);
    repeat (PUW) @(posedge ref_clk);
    fr(16, {48'h0, OP_WR_LOCK, 8'h00});
    rdlock(16'h0303);
    $display("factory lock test done");
  endtask : t_factory

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial
  begin
    do_reset();
    t_power_up();
    t_main();
    t_otp();
    t_lock();
    t_factory();
    final_report();
  end
endmodule : tb_secured_otp_region_control
